// File: bert_pkg.sv
`default_nettype none
package bert_pkg;

  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SEED_W = 32;
  localparam int unsigned SEL_W = 5;
  localparam int unsigned RATE_W = 3;
  localparam int unsigned RATE_COUNT_W = 24;

  localparam logic [ADDR_W-1:0] PATTERN_CONFIGURATION_ADDR = 11'h062;
  localparam logic [ADDR_W-1:0] SEED_PATTERN_LOW_ADDR = 11'h064;
  localparam logic [ADDR_W-1:0] SEED_PATTERN_HIGH_ADDR = 11'h066;
  localparam logic [ADDR_W-1:0] TX_ERROR_INSERTION_CONTROL_ADDR = 11'h068;

  localparam logic [DATA_W-1:0] PATTERN_CONFIGURATION_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] SEED_PATTERN_LOW_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] SEED_PATTERN_HIGH_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] TX_ERROR_INSERTION_CONTROL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] PATTERN_CONFIGURATION_MASK = 16'h1F7F;
  localparam logic [DATA_W-1:0] TX_ERROR_INSERTION_CONTROL_MASK = 16'h003F;

  localparam int unsigned LENGTH_FEEDBACK_LSB = 0;
  localparam int unsigned PATTERN_TYPE_BIT = 5;
  localparam int unsigned QUASI_RANDOM_BIT = 6;
  localparam int unsigned TAP_FEEDBACK_LSB = 8;
  localparam int unsigned MANUAL_SOURCE_BIT = 0;
  localparam int unsigned SINGLE_TRIGGER_BIT = 1;
  localparam int unsigned SINGLE_ENABLE_BIT = 2;
  localparam int unsigned ERROR_RATE_LSB = 3;

  // x^20 + x^17 + 1, stored as stage number minus one
  localparam logic [SEL_W-1:0] QUASI_LENGTH_SEL = 5'h13;
  localparam logic [SEL_W-1:0] QUASI_TAP_SEL = 5'h10;
  localparam logic [SEED_W-1:0] QUASI_SEED = 32'hFFFFFFFF;
  localparam int unsigned QUASI_ZERO_RUN = 14;

  localparam logic [RATE_W-1:0] RATE_DISABLED = 3'h0;

  typedef struct packed {
    logic              quasi_random_enable;
    logic              pattern_type_select;
    logic [SEL_W-1:0]  length_feedback_select;
    logic [SEL_W-1:0]  tap_feedback_select;
    logic [SEED_W-1:0] seed_pattern_value;
  } gen_config_type;

  // bits between two inserted errors, minus one
  function automatic logic [RATE_COUNT_W-1:0] decade_last(input logic [RATE_W-1:0] rate);
    logic [RATE_COUNT_W-1:0] result;
    result = 24'h000000;
    case (rate)
      3'h1: result = 24'h000009;
      3'h2: result = 24'h000063;
      3'h3: result = 24'h0003E7;
      3'h4: result = 24'h00270F;
      3'h5: result = 24'h01869F;
      3'h6: result = 24'h0F423F;
      3'h7: result = 24'h98967F;
      default: result = 24'h000000;
    endcase
    return result;
  endfunction

endpackage
`default_nettype wire

// File: bert_tx_generator.sv
`timescale 1ns/1ps
`default_nettype none
module bert_tx_generator (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    load,
  input  wire bert_pkg::gen_config_type load_config,
  input  wire logic                    advance,
  output logic                         gen_bit
);
  import bert_pkg::*;

  localparam int unsigned RUN_TOP = int'(QUASI_LENGTH_SEL) - 1;

  typedef struct packed {
    logic [SEED_W-1:0] shift;
    logic [SEL_W-1:0]  length_sel;
    logic [SEL_W-1:0]  tap_sel;
    logic              repetitive;
    logic              quasi;
  } gen_state_type;

  gen_state_type state;
  gen_state_type next_state;
  logic          feedback;

  always_comb begin
    next_state = state;
    feedback = state.shift[state.length_sel];
    if (!state.repetitive) begin
      feedback = feedback ^ state.shift[state.tap_sel];
    end
    if (load) begin
      if (load_config.quasi_random_enable) begin
        next_state.shift = QUASI_SEED;
        next_state.length_sel = QUASI_LENGTH_SEL;
        next_state.tap_sel = QUASI_TAP_SEL;
        next_state.repetitive = 1'b0;
        next_state.quasi = 1'b1;
      end else begin
        next_state.shift = load_config.seed_pattern_value;
        next_state.length_sel = load_config.length_feedback_select;
        next_state.tap_sel = load_config.tap_feedback_select;
        next_state.repetitive = load_config.pattern_type_select;
        next_state.quasi = 1'b0;
      end
    end else if (advance) begin
      next_state.shift = {state.shift[SEED_W-2:0], feedback};
    end
  end

  always_comb begin
    // output stage is stage n, so bit 31 leads at length 32
    gen_bit = state.shift[state.length_sel];
    // only the output is forced; the register keeps its true sequence
    if (state.quasi && (state.shift[RUN_TOP -: QUASI_ZERO_RUN] == '0)) begin
      gen_bit = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire

// File: bert_pattern_generator.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - load rising edge copies type, quasi, length, tap and seed into generator.
// - another load needs the load bit low then high again.
// - invert enable set inverts every outgoing bit; clear passes unchanged.
// - tap feedback comes from stage tap field plus one, bits 12 to 8.
// - tap field ignored in repetitive mode.
// - length feedback comes from stage length field plus one, bits 4 to 0.
// - pseudo-random feedback is stage n XOR stage y.
// - repetitive feedback is stage n alone, period n bits.
// - type bit 5 low selects pseudo-random, high selects repetitive.
// - quasi-random enable overrides settings with x^20 + x^17 + 1.
// - quasi-random output forced one when next fourteen bits are zero.
// - 32-bit seed starts pseudo-random runs, is the repetitive pattern.
// - bit 31 of seed goes out first at length 32.
// - bit 31 of seed is the first received bit of a 32-bit pattern.
// - rate field n inverts one bit per 10^n; zero disables.
// - rate insertion starts on a register write with nonzero rate.
// - rate rewrite while running takes effect after the next old-rate error.
// - enabled trigger rising edge inverts one bit; extra edges merge.
// - source select high takes single errors from the manual input pin.
module bert_pattern_generator (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic [bert_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic                          reg_write,
  input  wire logic                          reg_read,
  input  wire logic [bert_pkg::DATA_W-1:0]   reg_wdata,
  output logic      [bert_pkg::DATA_W-1:0]   reg_rdata,
  output logic                               reg_rdata_valid,
  input  wire logic                          tx_pattern_load,
  input  wire logic                          tx_invert_enable,
  input  wire logic                          manual_error_input,
  input  wire logic                          tx_bit_enable,
  output logic                               tx_bit_out,
  output logic                               tx_bit_valid,
  output logic                               tx_error_inserted,
  output logic      [bert_pkg::SEED_W-1:0]   rx_pattern_value
);
  import bert_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0]       pattern_configuration;
    logic [DATA_W-1:0]       seed_pattern_low;
    logic [DATA_W-1:0]       seed_pattern_high;
    logic [DATA_W-1:0]       tx_error_insertion_control;
    logic                    load_prev;
    logic                    trigger_prev;
    logic                    manual_sync1;
    logic                    manual_sync2;
    logic                    manual_prev;
    logic [RATE_W-1:0]       active_rate;
    logic [RATE_W-1:0]       pending_rate;
    logic                    pending_valid;
    logic [RATE_COUNT_W-1:0] rate_count;
    logic                    single_pending;
    logic                    out_bit;
    logic                    out_valid;
    logic                    out_error;
    logic [DATA_W-1:0]       rdata;
    logic                    rdata_valid;
  } top_state_type;

  typedef enum logic [2:0] {
    sel_none,
    sel_pattern_configuration,
    sel_seed_pattern_low,
    sel_seed_pattern_high,
    sel_tx_error_insertion_control
  } reg_sel_type;

  // one decoder for both strobes keeps the read and write maps identical
  function automatic reg_sel_type decode_addr(input logic [ADDR_W-1:0] addr);
    reg_sel_type sel;
    sel = sel_none;
    if (addr == PATTERN_CONFIGURATION_ADDR) begin
      sel = sel_pattern_configuration;
    end else if (addr == SEED_PATTERN_LOW_ADDR) begin
      sel = sel_seed_pattern_low;
    end else if (addr == SEED_PATTERN_HIGH_ADDR) begin
      sel = sel_seed_pattern_high;
    end else if (addr == TX_ERROR_INSERTION_CONTROL_ADDR) begin
      sel = sel_tx_error_insertion_control;
    end
    return sel;
  endfunction

  top_state_type  state;
  top_state_type  next_state;
  gen_config_type gen_config;
  logic           gen_bit;
  logic           load_edge;
  logic           single_edge;
  logic           manual_source;
  logic           rate_error;
  logic           single_error;
  logic           bit_error;
  logic [RATE_W-1:0] written_rate;
  reg_sel_type    addr_sel;

  // live register view; software keeps it steady around a load
  always_comb begin
    gen_config.quasi_random_enable =
      state.pattern_configuration[QUASI_RANDOM_BIT];
    gen_config.pattern_type_select =
      state.pattern_configuration[PATTERN_TYPE_BIT];
    gen_config.length_feedback_select =
      state.pattern_configuration[LENGTH_FEEDBACK_LSB +: SEL_W];
    gen_config.tap_feedback_select =
      state.pattern_configuration[TAP_FEEDBACK_LSB +: SEL_W];
    gen_config.seed_pattern_value =
      {state.seed_pattern_high, state.seed_pattern_low};
  end

  // load only on a low-to-high step; a held bit does nothing
  assign load_edge = tx_pattern_load && !state.load_prev;

  bert_tx_generator u_generator (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .load        (load_edge),
    .load_config (gen_config),
    .advance     (tx_bit_enable),
    .gen_bit     (gen_bit)
  );

  assign manual_source =
    state.tx_error_insertion_control[MANUAL_SOURCE_BIT];
  assign written_rate = reg_wdata[ERROR_RATE_LSB +: RATE_W];
  assign addr_sel = decode_addr(reg_addr);

  always_comb begin
    if (manual_source) begin
      // edge taken after the synchroniser, never from its first stage
      single_edge = state.manual_sync2 && !state.manual_prev;
    end else begin
      single_edge = state.tx_error_insertion_control[SINGLE_TRIGGER_BIT] &&
                    !state.trigger_prev;
    end
    if (!state.tx_error_insertion_control[SINGLE_ENABLE_BIT]) begin
      single_edge = 1'b0;
    end
  end

  always_comb begin
    rate_error = 1'b0;
    if (tx_bit_enable && (state.active_rate != RATE_DISABLED)) begin
      rate_error = (state.rate_count == decade_last(state.active_rate));
    end
    single_error = tx_bit_enable && state.single_pending;
    bit_error = rate_error || single_error;
  end

  always_comb begin
    next_state = state;
    next_state.load_prev = tx_pattern_load;
    next_state.trigger_prev = state.tx_error_insertion_control[SINGLE_TRIGGER_BIT];
    next_state.manual_sync1 = manual_error_input;
    next_state.manual_sync2 = state.manual_sync1;
    next_state.manual_prev = state.manual_sync2;
    next_state.rdata_valid = 1'b0;

    // register writes
    if (reg_write) begin
      case (addr_sel)
        sel_pattern_configuration: begin
          next_state.pattern_configuration = reg_wdata & PATTERN_CONFIGURATION_MASK;
        end
        sel_seed_pattern_low: begin
          next_state.seed_pattern_low = reg_wdata;
        end
        sel_seed_pattern_high: begin
          next_state.seed_pattern_high = reg_wdata;
        end
        sel_tx_error_insertion_control: begin
          next_state.tx_error_insertion_control =
            reg_wdata & TX_ERROR_INSERTION_CONTROL_MASK;
        end
        default: begin
        end
      endcase
    end

    // register reads, one cycle later; unmapped addresses read zero
    if (reg_read) begin
      next_state.rdata_valid = 1'b1;
      case (addr_sel)
        sel_pattern_configuration: begin
          next_state.rdata = state.pattern_configuration;
        end
        sel_seed_pattern_low: begin
          next_state.rdata = state.seed_pattern_low;
        end
        sel_seed_pattern_high: begin
          next_state.rdata = state.seed_pattern_high;
        end
        sel_tx_error_insertion_control: begin
          next_state.rdata = state.tx_error_insertion_control;
        end
        default: begin
          next_state.rdata = '0;
        end
      endcase
    end

    // rate counter moves only with transmitted bits
    if (tx_bit_enable && (state.active_rate != RATE_DISABLED)) begin
      if (rate_error) begin
        next_state.rate_count = '0;
        if (state.pending_valid) begin
          next_state.active_rate = state.pending_rate;
          next_state.pending_valid = 1'b0;
        end
      end else begin
        next_state.rate_count = state.rate_count + 1'b1;
      end
    end

    // a write while idle starts at once; while running it waits its turn
    if (reg_write && (addr_sel == sel_tx_error_insertion_control)) begin
      if (next_state.active_rate == RATE_DISABLED) begin
        next_state.active_rate = written_rate;
        next_state.rate_count = '0;
        next_state.pending_valid = 1'b0;
      end else begin
        next_state.pending_rate = written_rate;
        next_state.pending_valid = 1'b1;
      end
    end

    // one pending error no matter how many edges; a new edge beats the clear
    if (single_error) begin
      next_state.single_pending = 1'b0;
    end
    if (single_edge) begin
      next_state.single_pending = 1'b1;
    end

    // inversion and errors act after the generator
    next_state.out_valid = tx_bit_enable;
    next_state.out_error = bit_error;
    if (tx_bit_enable) begin
      next_state.out_bit = gen_bit ^ tx_invert_enable ^ bit_error;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= '0;
      state.pattern_configuration <= PATTERN_CONFIGURATION_RESET;
      state.seed_pattern_low <= SEED_PATTERN_LOW_RESET;
      state.seed_pattern_high <= SEED_PATTERN_HIGH_RESET;
      state.tx_error_insertion_control <= TX_ERROR_INSERTION_CONTROL_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign reg_rdata_valid = state.rdata_valid;
  assign tx_bit_out = state.out_bit;
  assign tx_bit_valid = state.out_valid;
  assign tx_error_inserted = state.out_error;
  // receive checker compares bit 31 first
  assign rx_pattern_value =
    {state.seed_pattern_high, state.seed_pattern_low};

endmodule
`default_nettype wire

// File: bert_pattern_generator_props.sv
`timescale 1ns/1ps
`default_nettype none
module bert_pattern_generator_props (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [10:0] reg_addr,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rdata_valid,
  input wire logic        tx_pattern_load,
  input wire logic        tx_invert_enable,
  input wire logic        manual_error_input,
  input wire logic        tx_bit_enable,
  input wire logic        tx_bit_out,
  input wire logic        tx_bit_valid,
  input wire logic        tx_error_inserted,
  input wire logic [31:0] rx_pattern_value
);
  import bert_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property seed_high_p;
    reg_write && reg_addr == SEED_PATTERN_HIGH_ADDR |=>
      rx_pattern_value[31:16] == $past(reg_wdata);
  endproperty
  AST_VALID_AFTER_EN: assert property (tx_bit_enable |=> tx_bit_valid)
    else $error("bit not issued");
  AST_NO_VALID_IDLE: assert property (!tx_bit_enable |=> !tx_bit_valid)
    else $error("bit without enable");
  AST_ERR_ON_BIT: assert property (tx_error_inserted |-> tx_bit_valid)
    else $error("error flag off a bit");
  AST_READ_ANSWER: assert property (reg_read |=> reg_rdata_valid)
    else $error("read not answered");
  AST_NO_STRAY_ANSWER: assert property (!reg_read |=> !reg_rdata_valid)
    else $error("answer without read");
  AST_RDATA_HOLD: assert property (!reg_rdata_valid && !$past(rst) |-> $stable(reg_rdata))
    else $error("read data moved");
  AST_BIT_HOLD: assert property (!tx_bit_valid && !$past(rst) |-> $stable(tx_bit_out))
    else $error("bit moved between enables");
  AST_SEED_HIGH: assert property (seed_high_p)
    else $error("seed high half not shown");
  cover property (tx_error_inserted);
  cover property (reg_rdata_valid && reg_rdata != 16'h0000);
  cover property (tx_bit_valid [*8]);
endmodule
`default_nettype wire

// File: bert_framer_model.sv
`timescale 1ns/1ps
`default_nettype none
module bert_framer_model (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic stall,
  input  wire logic pulse_req,
  output logic      tx_bit_enable,
  output logic      manual_error_input
);
  logic [1:0] hold;
  // bits offered only inside a run; stalls stand for a slow line
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_bit_enable <= 1'h0;
      manual_error_input <= 1'h0;
      hold <= 2'h0;
    end else begin
      tx_bit_enable <= run & ~stall;
      hold <= pulse_req ? 2'h3 : hold - {1'h0, hold != 2'h0};
      manual_error_input <= pulse_req | (hold != 2'h0);
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module testbench;
  import bert_pkg::*;
  logic [10:0] reg_addr = 11'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, pat_cfg, lo, hi, tei, e_rd;
  logic [31:0] rx_pattern_value, sh, e_rx, r;
  logic        sys_clk = 1'h0, rst = 1'h1, reg_write = 1'h0, reg_read = 1'h0, run = 1'h0;
  logic        tx_pattern_load = 1'h0, tx_invert_enable = 1'h0, stall = 1'h0, pulse_req = 1'h0;
  logic        reg_rdata_valid, tx_bit_enable, manual_error_input, tx_bit_out, tx_bit_valid;
  logic        tx_error_inserted, pl, pm, ld, raw, hit, sng, pendv, prbs, qr;
  logic        e_valid, e_bit, e_err, e_rv;
  int          len, tap, act, pend, cnt, num_errors = 0, n_compared = 0, seed = 32'h2F6993F8;
  logic [10:0] addrs[6] = '{11'h060, 11'h062, 11'h064, 11'h066, 11'h068, 11'h06A};
  logic [15:0] cfgs[6] = '{16'h003F, 16'h1F27, 16'h0020, 16'h1B1F, 16'h0506, 16'h1040};
  bert_pattern_generator u_bert_pattern_generator (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .tx_pattern_load(tx_pattern_load),
    .tx_invert_enable(tx_invert_enable), .manual_error_input(manual_error_input),
    .tx_bit_enable(tx_bit_enable), .tx_bit_out(tx_bit_out), .tx_bit_valid(tx_bit_valid),
    .tx_error_inserted(tx_error_inserted), .rx_pattern_value(rx_pattern_value));
  bert_framer_model u_framer (.sys_clk(sys_clk), .rst(rst), .run(run), .stall(stall),
    .pulse_req(pulse_req), .tx_bit_enable(tx_bit_enable), .manual_error_input(manual_error_input));
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (rst) begin
      {pat_cfg, lo, hi, tei, sh} = 96'h0;
      {len, tap, act, pend, cnt} = 160'h0;
      {pl, pm, sng, pendv, prbs, qr} = 6'h0;
      {e_valid, e_bit, e_err, e_rv, e_rd, e_rx} <= 52'h0;
    end else begin
      ld = tx_pattern_load & ~pl;
      if (tx_bit_enable) begin
        raw = sh[len];
        if (qr && sh[18:5] == 14'h0) raw = 1'h1;
        hit = 1'h0;
        if (act != 0) cnt++;
        if (act != 0 && cnt == 10 ** act) begin
          hit = 1'h1;
          cnt = 0;
          if (pendv) act = pend;
          pendv = 1'h0;
        end
        e_bit <= raw ^ tx_invert_enable ^ (hit | sng);
        e_err <= hit | sng;
        sng = 1'h0;
        if (!ld) sh = {sh[30:0], sh[len] ^ (prbs & sh[tap])};
      end
      if (ld && pat_cfg[6]) begin
        {len, tap, prbs, qr, sh} = {32'h13, 32'h10, 2'h3, 32'hFFFFFFFF};
      end else if (ld) begin
        len = {27'h0, pat_cfg[4:0]};
        tap = {27'h0, pat_cfg[12:8]};
        {prbs, qr} = {~pat_cfg[5], 1'h0};
        sh = {hi, lo};
      end
      if (manual_error_input && !pm && tei[0] && tei[2]) sng = 1'h1;
      pm = manual_error_input;
      pl = tx_pattern_load;
      e_valid <= tx_bit_enable;
      e_rv <= reg_read;
      if (reg_read) case (reg_addr)
        PATTERN_CONFIGURATION_ADDR: e_rd <= pat_cfg;
        SEED_PATTERN_LOW_ADDR: e_rd <= lo;
        SEED_PATTERN_HIGH_ADDR: e_rd <= hi;
        TX_ERROR_INSERTION_CONTROL_ADDR: e_rd <= tei;
        default: e_rd <= 16'h0;
      endcase
      if (reg_write) case (reg_addr)
        PATTERN_CONFIGURATION_ADDR: pat_cfg = reg_wdata & 16'h1F7F;
        SEED_PATTERN_LOW_ADDR: lo = reg_wdata;
        SEED_PATTERN_HIGH_ADDR: hi = reg_wdata;
        TX_ERROR_INSERTION_CONTROL_ADDR: begin
          if (reg_wdata[2:0] == 3'h6 && !tei[1]) sng = 1'h1;
          if (act == 0) {act, cnt} = {29'h0, reg_wdata[5:3], 32'h0};
          else {pendv, pend} = {1'h1, 29'h0, reg_wdata[5:3]};
          tei = reg_wdata & 16'h003F;
        end
        default: ;
      endcase
      e_rx <= {hi, lo};
    end
  end
  always @(negedge sys_clk) begin
    if (!rst) begin
      `CHK(tx_bit_valid, e_valid)
      if (e_valid) `CHK(tx_bit_out, e_bit)
      if (e_valid) `CHK(tx_error_inserted, e_err)
      `CHK(reg_rdata_valid, e_rv)
      if (e_rv) `CHK(reg_rdata, e_rd)
      `CHK(rx_pattern_value, e_rx)
    end
  end
  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge sys_clk);
    reg_write <= 1'h0;
  endtask
  task automatic rd(input logic [10:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge sys_clk);
    reg_read <= 1'h0;
  endtask
  task automatic bits(input int n, input logic slow);
    repeat (n) begin
      @(posedge sys_clk);
      r = $random(seed);
      run <= 1'h1;
      stall <= slow & r[0];
      tx_invert_enable <= r[1];
    end
    @(posedge sys_clk);
    run <= 1'h0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic pulse;
    @(posedge sys_clk);
    pulse_req <= 1'h1;
    @(posedge sys_clk);
    pulse_req <= 1'h0;
    repeat (8) @(posedge sys_clk);
    bits(6, 1'h0);
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #600000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'h0;
    foreach (addrs[i]) rd(addrs[i]);
    // rate field kept zero: a stray slow rate would hold off later rate writes
    foreach (addrs[i]) wr(addrs[i], 16'($random(seed)) & 16'hFFC7);
    foreach (addrs[i]) rd(addrs[i]);
    foreach (cfgs[i]) begin
      wr(PATTERN_CONFIGURATION_ADDR, cfgs[i]);
      wr(SEED_PATTERN_LOW_ADDR, 16'($random(seed)));
      wr(SEED_PATTERN_HIGH_ADDR, 16'($random(seed)));
      @(posedge sys_clk);
      tx_pattern_load <= 1'h1;
      repeat (5) @(posedge sys_clk);
      if (i == 2) wr(PATTERN_CONFIGURATION_ADDR, 16'h0027);
      bits(i == 5 ? 3000 : 70, i[0]);
      tx_pattern_load <= 1'h0;
    end
    for (int k = 1; k <= 4; k++) begin
      wr(TX_ERROR_INSERTION_CONTROL_ADDR, 16'(k << 3));
      bits(2 * 10 ** k + 20, 1'h0);
    end
    wr(TX_ERROR_INSERTION_CONTROL_ADDR, 16'h0000);
    bits(10020, 1'h0);
    wr(TX_ERROR_INSERTION_CONTROL_ADDR, 16'h0004);
    wr(TX_ERROR_INSERTION_CONTROL_ADDR, 16'h0006);
    wr(TX_ERROR_INSERTION_CONTROL_ADDR, 16'h0004);
    wr(TX_ERROR_INSERTION_CONTROL_ADDR, 16'h0006);
    bits(6, 1'h0);
    wr(TX_ERROR_INSERTION_CONTROL_ADDR, 16'h0004);
    wr(TX_ERROR_INSERTION_CONTROL_ADDR, 16'h0005);
    pulse;
    wr(TX_ERROR_INSERTION_CONTROL_ADDR, 16'h0001);
    pulse;
    tally_and_finish;
  end
endmodule
bind bert_pattern_generator bert_pattern_generator_props u_props (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rdata_valid(reg_rdata_valid), .tx_pattern_load(tx_pattern_load),
  .tx_invert_enable(tx_invert_enable), .manual_error_input(manual_error_input),
  .tx_bit_enable(tx_bit_enable), .tx_bit_out(tx_bit_out), .tx_bit_valid(tx_bit_valid),
  .tx_error_inserted(tx_error_inserted), .rx_pattern_value(rx_pattern_value));
`default_nettype wire
